// ### gpc_pin_config_bank.sv
// Decided for this implementation: register access over Wishbone.
`default_nettype none
module gpc_pin_config_bank
	import gpc_pkg::*;
(
	input  wire logic        clk_i,
	input  wire logic        rst_i,
	input  wire logic        cyc_i,
	input  wire logic        stb_i,
	input  wire logic        we_i,
	input  wire logic [31:0] adr_i,
	input  wire logic [3:0]  sel_i,
	input  wire logic [31:0] dat_i,
	output logic      [31:0] dat_o,
	output logic             ack_o,
	// order of pin vectors: [0]=pin3, [1]=second-port pin3, [2]=pin5, [3]=pin6
	input  wire logic [3:0]  remote_val_i,
	input  wire logic [3:0]  func_val_i,
	input  wire logic [3:0]  pin_in_i,
	output logic      [3:0]  pin_out_o,
	output logic      [3:0]  pin_oe_o
);
	gpc_state_type s_q;
	gpc_state_type s_d;
	logic [7:0]    idx;
	logic          hit;
	logic [1:0]    drv [NPINS];
	logic [3:0]    fld [NPINS];

	assign idx = adr_i[ADR_IDX_HI:ADR_IDX_LO];
	assign hit = cyc_i && stb_i && s_q.bus == GPC_IDLE;

	// pin three fields go to exactly one twin; the idle twin is left as input
	always_comb begin
		fld[0] = s_q.port_sel ? {1'b0, 1'b0, MODE_GP_IN} : s_q.pin3_ctrl[PIN_HI_BASE-1:0];
		fld[1] = s_q.port_sel ? s_q.pin3_ctrl[PIN_HI_BASE-1:0] : {1'b0, 1'b0, MODE_GP_IN};
		fld[2] = s_q.pin56_ctrl[PIN_HI_BASE-1:0];
		fld[3] = s_q.pin56_ctrl[CTRL_MSB:PIN_HI_BASE];
	end

	// pads are combinational so remote and functional values pass without a cycle of delay
	genvar g;
	generate
		for (g = 0; g < NPINS; g++) begin : g_pin
			assign drv[g]       = gpc_pin_drive(fld[g], remote_val_i[g], func_val_i[g]);
			assign pin_oe_o[g]  = drv[g][1];
			assign pin_out_o[g] = drv[g][0];
		end
	endgenerate

	always_comb begin
		s_d = s_q;
		// pin inputs are asynchronous; two stages before software sees them
		s_d.in_meta = pin_in_i;
		s_d.in_sync = s_q.in_meta;
		case (s_q.bus)
			GPC_IDLE: begin
				if (hit) begin
					s_d.bus   = GPC_ACK;
					s_d.rdata = 32'h0;
					case (idx)
						PIN_THREE_CONTROL_IDX: begin
							s_d.rdata[7:0] = s_q.pin3_ctrl;
							if (we_i && sel_i[0])
								s_d.pin3_ctrl = dat_i[7:0];
						end
						PINS_FIVE_SIX_CONTROL_IDX: begin
							s_d.rdata[7:0] = s_q.pin56_ctrl;
							if (we_i && sel_i[0])
								s_d.pin56_ctrl = dat_i[7:0];
						end
						PORT_SELECT_IDX: begin
							s_d.rdata[0] = s_q.port_sel;
							if (we_i && sel_i[0])
								s_d.port_sel = dat_i[0];
						end
						PIN_STATE_IDX: s_d.rdata[NPINS-1:0] = s_q.in_sync;
						// unmapped indexes still answer so a stray access cannot hang the bus
						default: s_d.rdata = 32'h0;
					endcase
				end
			end
			GPC_ACK: s_d.bus = GPC_IDLE;
			default: s_d.bus = GPC_IDLE;
		endcase
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			s_q.bus        <= GPC_IDLE;
			s_q.pin3_ctrl  <= CTRL_RESET;
			s_q.pin56_ctrl <= CTRL_RESET;
			s_q.port_sel   <= 1'b0;
			s_q.rdata      <= 32'h0;
			s_q.in_meta    <= '0;
			s_q.in_sync    <= '0;
		end else
			s_q <= s_d;
	end

	assign ack_o = s_q.bus == GPC_ACK;
	assign dat_o = s_q.rdata;

	property p_local_out;
		@(posedge clk_i) disable iff (rst_i)
		(fld[2][FLD_REMOTE] == 1'b0 && fld[2][FLD_DIR] == 1'b0 && fld[2][FLD_EN] == 1'b1)
			|-> (pin_oe_o[2] && pin_out_o[2] == fld[2][FLD_VALUE]);
	endproperty
	a_local_out: assert property (p_local_out) else $error("pin5 local value not driven");

	property p_remote;
		@(posedge clk_i) disable iff (rst_i)
		s_q.pin56_ctrl[PIN_HI_BASE+FLD_REMOTE] |-> (pin_oe_o[3] && pin_out_o[3] == remote_val_i[3]);
	endproperty
	a_remote: assert property (p_remote) else $error("pin6 remote value not driven");

	property p_tristate;
		@(posedge clk_i) disable iff (rst_i)
		(!s_q.pin56_ctrl[FLD_REMOTE] && s_q.pin56_ctrl[FLD_DIR]) |-> !pin_oe_o[2];
	endproperty
	a_tristate: assert property (p_tristate) else $error("pin5 driven in tri-state or input");

	property p_func;
		@(posedge clk_i) disable iff (rst_i)
		(s_q.pin56_ctrl[FLD_REMOTE+PIN_HI_BASE:PIN_HI_BASE] == 3'h0)
			|-> (pin_oe_o[3] && pin_out_o[3] == func_val_i[3]);
	endproperty
	a_func: assert property (p_func) else $error("pin6 functional output wrong");

	property p_write56;
		@(posedge clk_i) disable iff (rst_i)
		(hit && we_i && sel_i[0] && idx == PINS_FIVE_SIX_CONTROL_IDX)
			|=> (ack_o && s_q.pin56_ctrl == 8'($past(dat_i)));
	endproperty
	a_write56: assert property (p_write56) else $error("pin5/6 register write lost");

	property p_read3;
		@(posedge clk_i) disable iff (rst_i)
		(hit && !we_i && idx == PIN_THREE_CONTROL_IDX) |=> (dat_o[7:0] == s_q.pin3_ctrl);
	endproperty
	a_read3: assert property (p_read3) else $error("pin3 register readback wrong");

	property p_port_sel;
		@(posedge clk_i) disable iff (rst_i)
		(s_q.port_sel && s_q.pin3_ctrl[FLD_REMOTE]) |-> (pin_oe_o[1] && !pin_oe_o[0]);
	endproperty
	a_port_sel: assert property (p_port_sel) else $error("pin3 fields not steered");

	property p_reset;
		@(posedge clk_i) rst_i |=> (s_q.pin3_ctrl == CTRL_RESET && s_q.pin56_ctrl == CTRL_RESET
			&& !ack_o);
	endproperty
	a_reset: assert property (p_reset) else $error("config not zero after reset");

	// every request is answered in the next cycle and ack never stretches
	property p_ack_next;
		@(posedge clk_i) disable iff (rst_i)
		hit |=> ack_o;
	endproperty
	a_ack_next: assert property (p_ack_next) else $error("request not acknowledged");

	property p_ack_pulse;
		@(posedge clk_i) disable iff (rst_i)
		ack_o |=> !ack_o;
	endproperty
	a_ack_pulse: assert property (p_ack_pulse) else $error("ack held over two cycles");

	property p_write3;
		@(posedge clk_i) disable iff (rst_i)
		(hit && we_i && sel_i[0] && idx == PIN_THREE_CONTROL_IDX)
			|=> (s_q.pin3_ctrl == 8'($past(dat_i)));
	endproperty
	a_write3: assert property (p_write3) else $error("pin3 register write lost");

	// a write with the low lane disabled must leave both control bytes alone
	property p_lane_off;
		@(posedge clk_i) disable iff (rst_i)
		(hit && we_i && !sel_i[0])
			|=> ($stable(s_q.pin3_ctrl) && $stable(s_q.pin56_ctrl));
	endproperty
	a_lane_off: assert property (p_lane_off) else $error("lane-off write changed config");

	property p_read56;
		@(posedge clk_i) disable iff (rst_i)
		(hit && !we_i && idx == PINS_FIVE_SIX_CONTROL_IDX)
			|=> (dat_o == {24'h0, s_q.pin56_ctrl});
	endproperty
	a_read56: assert property (p_read56) else $error("pin5/6 register readback wrong");

	property p_gp_in;
		@(posedge clk_i) disable iff (rst_i)
		(!s_q.pin56_ctrl[PIN_HI_BASE+FLD_REMOTE] && s_q.pin56_ctrl[PIN_HI_BASE+FLD_DIR]
			&& s_q.pin56_ctrl[PIN_HI_BASE+FLD_EN]) |-> !pin_oe_o[3];
	endproperty
	a_gp_in: assert property (p_gp_in) else $error("pin6 driven in input mode");

	property p_pin3_local;
		@(posedge clk_i) disable iff (rst_i)
		(!s_q.port_sel && s_q.pin3_ctrl[FLD_REMOTE:FLD_EN] == {1'b0, MODE_GP_OUT})
			|-> (pin_oe_o[0] && pin_out_o[0] == s_q.pin3_ctrl[FLD_VALUE]);
	endproperty
	a_pin3_local: assert property (p_pin3_local) else $error("pin3 local value not driven");

	// the twin that the select does not name must never drive
	property p_twin_idle;
		@(posedge clk_i) disable iff (rst_i)
		(s_q.port_sel && !pin_oe_o[0]) || (!s_q.port_sel && !pin_oe_o[1]);
	endproperty
	a_twin_idle: assert property (p_twin_idle) else $error("unselected pin3 twin driven");

	property p_twin_remote;
		@(posedge clk_i) disable iff (rst_i)
		(s_q.port_sel && s_q.pin3_ctrl[FLD_REMOTE]) |-> (pin_out_o[1] == remote_val_i[1]);
	endproperty
	a_twin_remote: assert property (p_twin_remote) else $error("twin remote value wrong");
endmodule // gpc_pin_config_bank
`default_nettype wire

// ### gpc_pkg.sv
`default_nettype none
package gpc_pkg;
	// register offsets are word indexes; byte address is four times the index
	localparam logic [7:0] PINS_FIVE_SIX_CONTROL_IDX = 8'h20;
	localparam logic [7:0] PIN_THREE_CONTROL_IDX     = 8'h1f;
	localparam logic [7:0] PORT_SELECT_IDX           = 8'h30;
	localparam logic [7:0] PIN_STATE_IDX             = 8'h31;
	localparam logic [7:0] CTRL_RESET                = 8'h00;
	localparam int         CTRL_MSB                  = 7;
	localparam int         ADR_IDX_HI                = 9;
	localparam int         ADR_IDX_LO                = 2;
	localparam int         FLD_VALUE                 = 3;
	localparam int         FLD_REMOTE                = 2;
	localparam int         FLD_DIR                   = 1;
	localparam int         FLD_EN                    = 0;
	localparam int         PIN_HI_BASE               = 4;
	localparam logic [1:0] MODE_FUNC                 = 2'h0;
	localparam logic [1:0] MODE_TRI                  = 2'h2;
	localparam logic [1:0] MODE_GP_OUT               = 2'h1;
	localparam logic [1:0] MODE_GP_IN                = 2'h3;
	localparam int         NPINS                     = 4;

	typedef enum logic [1:0] {
		GPC_IDLE,
		GPC_ACK
	} gpc_bus_type;

	typedef struct packed {
		gpc_bus_type bus;
		logic [7:0]  pin3_ctrl;
		logic [7:0]  pin56_ctrl;
		logic        port_sel;
		logic [31:0] rdata;
		logic [NPINS-1:0] in_meta;
		logic [NPINS-1:0] in_sync;
	} gpc_state_type;

	// decode a 4-bit pin field: returns {oe, out} given local, remote and functional values
	function automatic logic [1:0] gpc_pin_drive(input logic [3:0] f, input logic remote_v,
		input logic func_v);
		logic [1:0] r;
		r = 2'h0;
		if (f[FLD_REMOTE])
			r = {1'b1, remote_v};
		else begin
			case ({f[FLD_DIR], f[FLD_EN]})
				MODE_FUNC:   r = {1'b1, func_v};
				MODE_GP_OUT: r = {1'b1, f[FLD_VALUE]};
				MODE_TRI:    r = 2'h0;
				MODE_GP_IN:  r = 2'h0;
				default:     r = 2'h0;
			endcase
		end
		return r;
	endfunction
endpackage
`default_nettype wire

// ### gpc_remote_model.sv
`default_nettype none
module gpc_remote_model (
	input  wire logic       clk_i,
	input  wire logic       rst_i,
	output logic      [3:0] remote_val_o
);
	timeunit 1ns;
	timeprecision 1ps;
	// values from the far end change every cycle so a stale copy cannot pass
	always_ff @(posedge clk_i) begin
		if (rst_i)
			remote_val_o <= 4'h5;
		else
			remote_val_o <= {remote_val_o[2:0], remote_val_o[3] ^ remote_val_o[2]};
	end
endmodule // gpc_remote_model
`default_nettype wire

// ### tb_top.sv
`default_nettype none
module tb_top;
	import gpc_pkg::*;
	timeunit 1ns;
	timeprecision 1ps;
	logic        clk_i = 1'b0, rst_i = 1'b1, cyc_i = 1'b0, stb_i = 1'b0, we_i = 1'b0, ack_o;
	logic [31:0] adr_i = 32'h0, dat_i = 32'h0, dat_o, r;
	logic [3:0]  rv, fv = 4'hd, pin_in = 4'h0, pin_out_o, pin_oe_o, f[4];
	logic [3:0]  sel_i = 4'h0, bsel = 4'hf;
	logic [7:0]  p3, p56, ps;
	logic [1:0]  e;
	int          seed = 37429, errors = 0, samples_checked = 0, cycles = 0;
	gpc_pin_config_bank i_gpc_pin_config_bank (.clk_i, .rst_i, .cyc_i, .stb_i, .we_i, .adr_i,
		.sel_i, .dat_i, .dat_o, .ack_o, .remote_val_i(rv), .func_val_i(fv),
		.pin_in_i(pin_in), .pin_out_o, .pin_oe_o);
	gpc_remote_model i_gpc_remote_model (.clk_i, .rst_i, .remote_val_o(rv));
	initial forever #4 clk_i = ~clk_i;
	function automatic logic [1:0] drv(input logic [3:0] fl, input logic rm, input logic fn);
		if (fl[2])
			return {1'b1, rm};
		case (fl[1:0])
			2'h0: return {1'b1, fn};
			2'h1: return {1'b1, fl[3]};
			default: return 2'h0;
		endcase
	endfunction
	task automatic print_verdict();
		$display("checks %0d mismatches %0d", samples_checked, errors);
		if (errors == 0 && samples_checked > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	task automatic chk_reg(input string n, input logic [31:0] ex, input logic [31:0] s);
		samples_checked++;
		if (s !== ex) begin
			errors++;
			$display("[ERR] %s expected %h seen %h", n, ex, s);
		end
	endtask
	task automatic chk_bit(input string n, input logic ex, input logic s);
		samples_checked++;
		if (s !== ex) begin
			errors++;
			$display("[ERR] %s expected %b seen %b", n, ex, s);
		end
	endtask
	// one classic cycle; read data is taken at the edge where ack is seen
	task automatic wb(input logic w, input logic [31:0] a, input logic [7:0] d);
		cyc_i <= 1'b1;
		stb_i <= 1'b1;
		we_i <= w;
		sel_i <= bsel;
		adr_i <= a;
		dat_i <= {24'h0, d};
		// this wait ends when ack is seen; if ack never comes only the bench timeout ends it
		do
			@(posedge clk_i);
		while (ack_o !== 1'b1);
		r = dat_o;
		cyc_i <= 1'b0;
		stb_i <= 1'b0;
		@(posedge clk_i);
	endtask
	// not-selected pin three twin is expected tristate, encoded as field 2h
	task automatic chk_pins();
		f[0] = ps[0] ? 4'h2 : p3[3:0];
		f[1] = ps[0] ? p3[3:0] : 4'h2;
		f[2] = p56[3:0];
		f[3] = p56[7:4];
		for (int i = 0; i < 4; i++) begin
			e = drv(f[i], rv[i], fv[i]);
			chk_bit("pin_oe", e[1], pin_oe_o[i]);
			if (e[1])
				chk_bit("pin_out", e[0], pin_out_o[i]);
		end
	endtask
	always @(posedge clk_i) begin
		cycles++;
		if (cycles > 20000) begin
			errors++;
			print_verdict();
		end
	end
	initial begin
		{p3, p56, ps} = 24'h0;
		repeat (16) @(posedge clk_i);
		rst_i <= 1'b0;
		@(negedge clk_i);
		chk_pins();
		@(posedge clk_i);
		wb(1'b0, 32'h7c, 8'h0);
		chk_reg("pin3_reg_reset", 32'h0, r);
		wb(1'b0, 32'h80, 8'h0);
		chk_reg("pin56_reg_reset", 32'h0, r);
		wb(1'b1, 32'h84, 8'hff);
		wb(1'b0, 32'h84, 8'h0);
		chk_reg("unmapped", 32'h0, r);
		bsel = 4'he;
		wb(1'b1, 32'h80, 8'hff);
		bsel = 4'hf;
		wb(1'b0, 32'h80, 8'h0);
		chk_reg("pin56_lane_off", 32'h0, r);
		for (int k = 0; k < 64; k++) begin
			p3 = (k == 0) ? 8'hf4 : 8'($random(seed));
			p56 = 8'($random(seed));
			ps = 8'($random(seed));
			wb(1'b1, 32'h7c, p3);
			wb(1'b1, 32'h80, p56);
			wb(1'b1, 32'hc0, ps);
			wb(1'b0, 32'h7c, 8'h0);
			chk_reg("pin3_reg", {24'h0, p3}, r);
			wb(1'b0, 32'h80, 8'h0);
			chk_reg("pin56_reg", {24'h0, p56}, r);
			wb(1'b0, 32'hc0, 8'h0);
			chk_reg("port_sel_reg", {31'h0, ps[0]}, r);
			fv <= 4'($random(seed));
			pin_in <= 4'($random(seed));
			@(negedge clk_i);
			chk_pins();
			// two synchroniser stages must pass before the new pin levels can be read
			repeat (2) @(posedge clk_i);
			wb(1'b0, 32'hc4, 8'h0);
			chk_reg("pin_state", {28'h0, pin_in}, r);
		end
		rst_i <= 1'b1;
		repeat (3) @(posedge clk_i);
		rst_i <= 1'b0;
		{p3, p56, ps} = 24'h0;
		@(negedge clk_i);
		chk_pins();
		@(posedge clk_i);
		wb(1'b0, 32'h7c, 8'h0);
		chk_reg("pin3_reg_rerst", 32'h0, r);
		wb(1'b0, 32'hc0, 8'h0);
		chk_reg("port_sel_rerst", 32'h0, r);
		print_verdict();
	end
endmodule // tb_top
`default_nettype wire
